// ### verilog/lam_pkg.sv
// Constants and types for the link enable and alarm monitor.
// Assumes one 200 MHz clock shared by transmitter and receiver ends.
package lam_pkg;
   localparam int AW = 10;
   localparam int DW = 8;
   localparam int LANES = 4;
   localparam int NALM = 6;
   // Transmitter register offsets
   localparam logic [9:0] A_PM1 = 10'h037;
   localparam logic [9:0] A_SOFT_TRIG = 10'h06C;
   localparam logic [9:0] A_PM2 = 10'h29A;
   localparam logic [9:0] A_PM3 = 10'h29B;
   localparam logic [9:0] A_PM4 = 10'h29C;
   localparam logic [9:0] A_CTRL = 10'h200;
   localparam logic [9:0] A_PD = 10'h201;
   localparam logic [9:0] A_ALM = 10'h202;
   localparam logic [9:0] A_MASK = 10'h203;
   localparam logic [9:0] A_SUM = 10'h204;
   localparam logic [9:0] A_FIFO = 10'h205;
   localparam logic [9:0] A_LSTAT = 10'h206;
   // Reset and mode values
   localparam logic [7:0] PM1_RST = 8'h4B;
   localparam logic [7:0] PM1_LOWPWR = 8'h46;
   localparam logic [7:0] PM2_RST = 8'h0F;
   localparam logic [7:0] PM3_RST = 8'h04;
   localparam logic [7:0] PM3_FULL = 8'h04;
   localparam logic [7:0] PM4_RST = 8'h00;
   localparam logic [7:0] CTRL_RST = 8'h00;
   localparam logic [7:0] PD_RST = 8'h00;
   localparam logic [7:0] MASK_RST = 8'h00;
   // Control bit positions
   localparam int C_EN = 0;
   localparam int C_ENC64 = 1;
   localparam int C_SC0 = 2;
   localparam int C_CALEN = 3;
   localparam int C_FG = 4;
   localparam int C_LPTRIG = 5;
   localparam int C_PINSEL = 6;
   localparam int PD_A = 0;
   localparam int PD_B = 1;
   // Alarm bit positions
   localparam int AL_CPLL = 0;
   localparam int AL_SPLL = 1;
   localparam int AL_NODATA = 2;
   localparam int AL_REALIGN = 3;
   localparam int AL_CLK = 4;
   localparam int AL_FIFO = 5;
   // Counts in clock cycles, except the alignment phase length in multiframes
   localparam logic [7:0] LMFC_PERIOD = 8'd32;
   localparam logic [7:0] LEMC_PERIOD = 8'd64;
   localparam logic [1:0] INITIAL_LANE_ALIGNMENT_MF = 2'd3;
   localparam int TRANS_MIN_CLKS = 500;
   localparam int TRANS_MAX_CLKS = 1000;
   localparam logic [11:0] TRANS_DELAY = 12'((TRANS_MIN_CLKS + TRANS_MAX_CLKS) / 2);
   localparam logic [11:0] BG_SWAP_PERIOD = 12'd4000;
   // Receiver-side register offsets
   localparam logic [2:0] H_RBD = 3'h0;
   localparam logic [2:0] H_STAT = 3'h1;
   localparam logic [2:0] H_CTL = 3'h2;
   localparam logic [2:0] H_DADDR_LO = 3'h3;
   localparam logic [2:0] H_DADDR_HI = 3'h4;
   localparam logic [2:0] H_DDATA = 3'h5;
   localparam logic [2:0] H_GO = 3'h6;
   localparam logic [2:0] H_DRES = 3'h7;
   localparam int G_WR = 0;
   localparam int G_RD = 1;
   localparam int G_CLKCHK = 2;
   localparam int HC_SYNC = 0;
   localparam int HC_PD = 1;
   localparam int HC_CALIBRATION_TRIGGER_PIN = 2;
   typedef enum logic [1:0] {LK_OFF, LK_CGS, LK_INITIAL_LANE_ALIGNMENT, LK_DATA} lam_link_t;
endpackage

// ### verilog/lam_if.sv
// Link between transmitter and receiver ends: register port and pins.
// Assumes both ends run on the same clk.
`timescale 1ns/1ps
`default_nettype none
interface lam_if (input wire logic clk);
   import lam_pkg::*;
   logic [AW-1:0] addr;
   logic [DW-1:0] wdata;
   logic wr;
   logic rd;
   logic [DW-1:0] rdata;
   logic sysref;
   logic sync_n;
   logic cal_trig;
   logic pd_pin;
   logic cal_state;
   lam_link_t phase;
   modport dev (input addr, wdata, wr, rd, sysref, sync_n, cal_trig, pd_pin,
      output rdata, cal_state, phase);
   modport host (output addr, wdata, wr, rd, sysref, sync_n, cal_trig, pd_pin,
      input rdata, cal_state, phase);
endinterface
`default_nettype wire

// ### verilog/lam_dev.sv
// Transmitter end: link enable gating, frame counter, alarms, power modes.
// Assumes registers are reached through lam_if.dev, with read data one cycle later.
`timescale 1ns/1ps
`default_nettype none
module lam_dev
   import lam_pkg::*;
(
   input wire logic clk, // 200 MHz clock
   input wire logic rst_n, // Synchronous reset, active low
   lam_if.dev lk, // Register port and link pins
   input wire logic cpll_lock, // Converter PLL locked
   input wire logic spll_lock, // Serializer PLL locked
   input wire logic chan_a_clk, // Channel A half-rate clock
   input wire logic chan_b_clk, // Channel B half-rate clock
   input wire logic [LANES-1:0] fifo_ptr_err, // Lane FIFO pointer upset
   output logic link_rst, // Link block held in reset
   output logic ser_pd, // Serializers powered down
   output logic link_clk_en, // Link block clock enable
   output logic fifo_rst, // Synchronizing FIFO reset pulse
   output logic lmfc_edge, // Frame counter boundary pulse
   output logic core_swap, // Converter core transition pulse
   output logic glitch_ok, // Swap glitch at full-performance size
   output logic [DW-1:0] pm_cfg1, // Power mode setting one
   output logic [DW-1:0] pm_cfg2, // Power mode setting two
   output logic [DW-1:0] pm_cfg3, // Power mode setting three
   output logic [DW-1:0] pm_cfg4 // Power mode setting four
);
   localparam int NP = 6;
   logic [NP-1:0] s1_r, s2_r, d_r;
   logic [DW-1:0] ctrl_r, pd_r, mask_r, rdata_r, rd_mux;
   logic [NALM-1:0] alm_r, alm_ev, alm_w1c;
   logic [LANES-1:0] lane_fifo_error_r, lane_w1c;
   logic [7:0] cnt_r, period;
   logic [1:0] initial_lane_alignment_r;
   logic [11:0] tr_r, tr_nxt;
   lam_link_t st_r, st_nxt;
   logic en_d_r, summary_r, pin_r;
   logic link_rst_r, ser_pd_r, clk_en_r, fifo_rst_r, edge_r, swap_r, glitch_r;

   // Pin order: sysref, sync_n, cal_trig, pd_pin, chan_a, chan_b
   wire [NP-1:0] pins = {lk.sysref, lk.sync_n, lk.cal_trig, lk.pd_pin, chan_a_clk, chan_b_clk};
   wire sysref_s = s2_r[5];
   wire sync_n_s = s2_r[4];
   wire calibration_trigger_pin_rise = s2_r[3] & ~d_r[3];
   wire pd_s = s2_r[2];
   wire pd_exit = d_r[2] & ~s2_r[2];
   wire clka_s = s2_r[1];
   wire clkb_s = s2_r[0];
   wire sysref_rise = sysref_s & ~d_r[5];

   wire link_enable = ctrl_r[C_EN];
   wire enc64 = ctrl_r[C_ENC64];
   wire sc0 = ctrl_r[C_SC0];
   wire bg_cal = ctrl_r[C_CALEN] & ~ctrl_r[C_FG];
   wire wr_hit_ctrl = lk.wr && lk.addr == A_CTRL;

   function automatic logic hit(input logic [AW-1:0] a, input logic [AW-1:0] off);
      hit = a == off;
   endfunction

   // Two-flop synchronisers for every pin and foreign clock sample
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         s1_r <= 6'h10;
         s2_r <= 6'h10;
         d_r <= 6'h10;
      end else begin
         s1_r <= pins;
         s2_r <= s1_r;
         d_r <= s2_r;
      end
   end

   // Multiframe in 8b/10b, extended multiblock in 64b/66b: one counter
   assign period = enc64 ? LEMC_PERIOD : LMFC_PERIOD;
   wire lmfc_wrap = cnt_r == period - 8'd1;
   wire sysref_cap = sysref_rise & ~sc0;
   // Capture on the natural wrap leaves the count where it would be anyway
   wire realign = sysref_cap && !lmfc_wrap;

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         cnt_r <= 8'h00;
         edge_r <= 1'b0;
      end else begin
         if (sysref_cap || lmfc_wrap) begin
            cnt_r <= 8'h00;
         end else begin
            cnt_r <= cnt_r + 8'd1;
         end
         edge_r <= lmfc_wrap | sysref_cap;
      end
   end

   // Link sequencing; sync request behaves alike in either subclass
   always_comb begin
      st_nxt = st_r;
      unique case (st_r)
         LK_OFF: begin
            if (enc64 && lmfc_wrap) begin
               st_nxt = LK_DATA;
            end else if (!enc64 && !sync_n_s) begin
               st_nxt = LK_CGS;
            end
         end
         LK_CGS: begin
            if (sync_n_s && lmfc_wrap) begin
               st_nxt = LK_INITIAL_LANE_ALIGNMENT;
            end
         end
         LK_INITIAL_LANE_ALIGNMENT: begin
            if (!sync_n_s) begin
               st_nxt = LK_CGS;
            end else if (lmfc_wrap && initial_lane_alignment_r == INITIAL_LANE_ALIGNMENT_MF) begin
               st_nxt = LK_DATA;
            end
         end
         LK_DATA: begin
            if (!enc64 && !sync_n_s) begin
               st_nxt = LK_CGS;
            end
         end
      endcase
      if (!link_enable) begin
         st_nxt = LK_OFF;
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         st_r <= LK_OFF;
         initial_lane_alignment_r <= 2'd0;
      end else begin
         st_r <= st_nxt;
         if (st_r != LK_INITIAL_LANE_ALIGNMENT) begin
            initial_lane_alignment_r <= 2'd0;
         end else if (lmfc_wrap) begin
            initial_lane_alignment_r <= initial_lane_alignment_r + 2'd1;
         end
      end
   end

   // Disabled link: block in reset, serializers off, clocks stopped
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         en_d_r <= 1'b0;
         link_rst_r <= 1'b1;
         ser_pd_r <= 1'b1;
         clk_en_r <= 1'b0;
         fifo_rst_r <= 1'b0;
      end else begin
         en_d_r <= link_enable;
         link_rst_r <= ~link_enable;
         ser_pd_r <= ~link_enable;
         clk_en_r <= link_enable;
         fifo_rst_r <= link_enable & ~en_d_r;
      end
   end

   // Clocks only compared while both channels and the chip are up
   wire clk_cmp = link_enable & ~pd_r[PD_A] & ~pd_r[PD_B] & ~pd_s;
   wire clk_upset = (clk_cmp && clka_s != clkb_s) || pd_exit;

   assign alm_ev[AL_CPLL] = ~cpll_lock;
   assign alm_ev[AL_SPLL] = ~spll_lock;
   assign alm_ev[AL_NODATA] = st_r != LK_DATA;
   assign alm_ev[AL_REALIGN] = realign;
   assign alm_ev[AL_CLK] = clk_upset;
   assign alm_ev[AL_FIFO] = |(fifo_ptr_err & {LANES{link_enable}});
   assign alm_w1c = (lk.wr && hit(lk.addr, A_ALM)) ? lk.wdata[NALM-1:0] : '0;
   assign lane_w1c = (lk.wr && hit(lk.addr, A_FIFO)) ? lk.wdata[LANES-1:0] : '0;
   wire alarm_any = |(alm_r & ~mask_r[NALM-1:0]);

   // A new event in the clearing cycle keeps its flag set
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         alm_r <= '0;
         lane_fifo_error_r <= '0;
         summary_r <= 1'b0;
         pin_r <= 1'b0;
      end else begin
         alm_r <= (alm_r & ~alm_w1c) | alm_ev;
         lane_fifo_error_r <= (lane_fifo_error_r & ~lane_w1c) |
            (fifo_ptr_err & {LANES{link_enable}});
         summary_r <= alarm_any;
         pin_r <= ctrl_r[C_PINSEL] ? alarm_any : (tr_r != 12'd0);
      end
   end

   // Core swap timer: periodic, or armed by a trigger in low-power mode
   wire soft_trig = lk.wr && hit(lk.addr, A_SOFT_TRIG);
   wire trig = calibration_trigger_pin_rise | soft_trig;
   always_comb begin
      if (!bg_cal) begin
         tr_nxt = 12'd0;
      end else if (tr_r == 12'd0) begin
         tr_nxt = ctrl_r[C_LPTRIG] ? (trig ? TRANS_DELAY : 12'd0) : BG_SWAP_PERIOD;
      end else begin
         tr_nxt = tr_r - 12'd1;
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         tr_r <= 12'd0;
         swap_r <= 1'b0;
         glitch_r <= 1'b1;
      end else begin
         tr_r <= tr_nxt;
         swap_r <= bg_cal && tr_r == 12'd1;
         glitch_r <= pm_cfg3 >= PM3_FULL;
      end
   end

   // Register file
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         ctrl_r <= CTRL_RST;
         pd_r <= PD_RST;
         mask_r <= MASK_RST;
         pm_cfg1 <= PM1_RST;
         pm_cfg2 <= PM2_RST;
         pm_cfg3 <= PM3_RST;
         pm_cfg4 <= PM4_RST;
      end else if (lk.wr) begin
         if (wr_hit_ctrl) ctrl_r <= lk.wdata;
         if (hit(lk.addr, A_PD)) pd_r <= lk.wdata;
         if (hit(lk.addr, A_MASK)) mask_r <= lk.wdata;
         if (hit(lk.addr, A_PM1)) pm_cfg1 <= lk.wdata;
         if (hit(lk.addr, A_PM2)) pm_cfg2 <= lk.wdata;
         if (hit(lk.addr, A_PM3)) pm_cfg3 <= lk.wdata;
         if (hit(lk.addr, A_PM4)) pm_cfg4 <= lk.wdata;
      end
   end

   always_comb begin
      rd_mux = 8'h00;
      unique case (lk.addr)
         A_CTRL: rd_mux = ctrl_r;
         A_PD: rd_mux = pd_r;
         A_ALM: rd_mux = {2'b00, alm_r};
         A_MASK: rd_mux = mask_r;
         A_SUM: rd_mux = {7'h00, summary_r};
         A_FIFO: rd_mux = {4'h0, lane_fifo_error_r};
         A_LSTAT: rd_mux = {6'h00, st_r};
         A_PM1: rd_mux = pm_cfg1;
         A_PM2: rd_mux = pm_cfg2;
         A_PM3: rd_mux = pm_cfg3;
         A_PM4: rd_mux = pm_cfg4;
         default: rd_mux = 8'h00;
      endcase
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         rdata_r <= 8'h00;
      end else begin
         rdata_r <= lk.rd ? rd_mux : 8'h00;
      end
   end

   assign lk.rdata = rdata_r;
   assign lk.cal_state = pin_r;
   assign lk.phase = st_r;
   assign link_rst = link_rst_r;
   assign ser_pd = ser_pd_r;
   assign link_clk_en = clk_en_r;
   assign fifo_rst = fifo_rst_r;
   assign lmfc_edge = edge_r;
   assign core_swap = swap_r;
   assign glitch_ok = glitch_r;
endmodule
`default_nettype wire

// ### verilog/lam_host.sv
// Receiver end: elastic buffer release, sync request and register bridge.
// Assumes software on a plain port with read data one cycle later.
`timescale 1ns/1ps
`default_nettype none
module lam_host
   import lam_pkg::*;
(
   input wire logic clk, // 200 MHz clock
   input wire logic rst_n, // Synchronous reset, active low
   lam_if.host lk, // Register port and link pins
   input wire logic [2:0] addr, // Software address
   input wire logic [DW-1:0] wdata, // Software write data
   input wire logic wr, // Software write strobe
   input wire logic rd, // Software read strobe
   output logic [DW-1:0] rdata, // Read data, cycle after rd
   input wire logic sysref_in, // System reference from clock tree
   input wire logic [LANES-1:0] lane_arrived, // Lane data reached buffer
   output logic buf_release, // Elastic buffer release pulse
   output logic released // Buffers released, level
);
   logic [DW-1:0] rbd_r, hctl_r, ddata_r, dres_r, ctrl_sh_r, rdata_r, rd_mux;
   logic [AW-1:0] daddr_r, oaddr_r;
   logic [DW-1:0] owdata_r;
   logic owr_r, ord_r, pend_r, err_r, sync_n_r, cgs_seen_r, sysref_r, rel_r, reld_r;
   logic [2:0] seq_r;
   logic [1:0] cal_s1_r, cal_s2_r;
   logic [7:0] lcnt_r;
   logic [LANES-1:0] arr_r;

   wire go = wr && addr == H_GO;
   wire dev_en = ctrl_sh_r[C_EN];
   wire [7:0] period = ctrl_sh_r[C_ENC64] ? LEMC_PERIOD : LMFC_PERIOD;
   wire sysref_rise = sysref_in & ~sysref_r;

   // Power mode writes refused while the link or calibration runs, control changes that keep the link enabled while it runs
   function automatic logic guard_ok(input logic [AW-1:0] a, input logic [DW-1:0] d,
      input logic [DW-1:0] sh);
      logic pm;
      pm = a == A_PM1 || a == A_PM2 || a == A_PM3 || a == A_PM4;
      guard_ok = 1'b1;
      if (pm && (sh[C_EN] || sh[C_CALEN])) guard_ok = 1'b0;
      if (a == A_CTRL && sh[C_EN] && d[C_EN] && d != sh) guard_ok = 1'b0;
   endfunction

   // Clock check steps: disable, both channels up, enable, clear flag
   function automatic logic [17:0] seq_op(input logic [2:0] s, input logic [DW-1:0] sh);
      unique case (s)
         3'd1: seq_op = {A_CTRL, sh & ~8'h01};
         3'd2: seq_op = {A_PD, 8'h00};
         3'd3: seq_op = {A_CTRL, sh | 8'h01};
         default: seq_op = {A_ALM, 8'h10};
      endcase
   endfunction

   wire [17:0] op = seq_op(seq_r, ctrl_sh_r);
   wire pd_exit = wr && addr == H_CTL && hctl_r[HC_PD] && !wdata[HC_PD];
   wire user_wr = go && wdata[G_WR] && seq_r == 3'd0;
   wire user_ok = guard_ok(daddr_r, ddata_r, ctrl_sh_r);

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         seq_r <= 3'd0;
         owr_r <= 1'b0;
         ord_r <= 1'b0;
         oaddr_r <= 10'h000;
         owdata_r <= 8'h00;
         pend_r <= 1'b0;
         err_r <= 1'b0;
         ctrl_sh_r <= CTRL_RST;
         dres_r <= 8'h00;
      end else begin
         owr_r <= 1'b0;
         ord_r <= 1'b0;
         pend_r <= ord_r;
         if (pend_r) dres_r <= lk.rdata;
         if (seq_r != 3'd0) begin
            owr_r <= 1'b1;
            oaddr_r <= op[17:8];
            owdata_r <= op[7:0];
            if (op[17:8] == A_CTRL) ctrl_sh_r <= op[7:0];
            seq_r <= seq_r == 3'd4 ? 3'd0 : seq_r + 3'd1;
         end else if (pd_exit) begin
            seq_r <= 3'd4;
         end else if (go && wdata[G_CLKCHK]) begin
            seq_r <= 3'd1;
         end else if (user_wr) begin
            err_r <= ~user_ok;
            owr_r <= user_ok;
            oaddr_r <= daddr_r;
            owdata_r <= ddata_r;
            if (user_ok && daddr_r == A_CTRL) ctrl_sh_r <= ddata_r;
         end else if (go && wdata[G_RD]) begin
            ord_r <= 1'b1;
            oaddr_r <= daddr_r;
         end
      end
   end

   // Local frame counter, aligned by the same system reference
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         sysref_r <= 1'b0;
         lcnt_r <= 8'h00;
      end else begin
         sysref_r <= sysref_in;
         lcnt_r <= (sysref_rise || lcnt_r == period - 8'd1) ? 8'h00 : lcnt_r + 8'd1;
      end
   end

   // Release at programmed offset once all lanes are buffering
   wire link_up = lk.phase == LK_INITIAL_LANE_ALIGNMENT || lk.phase == LK_DATA;
   wire rel_now = link_up && &arr_r && !reld_r && lcnt_r == rbd_r;

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         arr_r <= '0;
         rel_r <= 1'b0;
         reld_r <= 1'b0;
         cgs_seen_r <= 1'b0;
         sync_n_r <= 1'b1;
      end else begin
         arr_r <= link_up ? (arr_r | lane_arrived) : '0;
         rel_r <= rel_now;
         reld_r <= link_up & (reld_r | rel_now);
         cgs_seen_r <= lk.phase == LK_CGS;
         sync_n_r <= ~(hctl_r[HC_SYNC] | (lk.phase == LK_CGS && !cgs_seen_r));
      end
   end

   // Status pin from the transmitter is asynchronous here
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         cal_s1_r <= 2'b00;
         cal_s2_r <= 2'b00;
      end else begin
         cal_s1_r <= {cal_s1_r[0], lk.cal_state};
         cal_s2_r <= {cal_s2_r[0], cal_s1_r[1]};
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         rbd_r <= 8'h00;
         hctl_r <= 8'h00;
         daddr_r <= 10'h000;
         ddata_r <= 8'h00;
      end else if (wr) begin
         if (addr == H_RBD) rbd_r <= wdata;
         if (addr == H_CTL) hctl_r <= wdata;
         if (addr == H_DADDR_LO) daddr_r[7:0] <= wdata;
         if (addr == H_DADDR_HI) daddr_r[9:8] <= wdata[1:0];
         if (addr == H_DDATA) ddata_r <= wdata;
      end
   end

   always_comb begin
      rd_mux = 8'h00;
      unique case (addr)
         H_RBD: rd_mux = rbd_r;
         H_STAT: rd_mux = {err_r, cal_s2_r[1], reld_r, seq_r != 3'd0 || pend_r || ord_r, arr_r};
         H_CTL: rd_mux = hctl_r;
         H_DADDR_LO: rd_mux = daddr_r[7:0];
         H_DADDR_HI: rd_mux = {6'h00, daddr_r[9:8]};
         H_DDATA: rd_mux = ddata_r;
         H_GO: rd_mux = 8'h00;
         H_DRES: rd_mux = dres_r;
      endcase
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         rdata_r <= 8'h00;
      end else begin
         rdata_r <= rd ? rd_mux : 8'h00;
      end
   end

   assign rdata = rdata_r;
   assign buf_release = rel_r;
   assign released = reld_r;
   assign lk.addr = oaddr_r;
   assign lk.wdata = owdata_r;
   assign lk.wr = owr_r;
   assign lk.rd = ord_r;
   assign lk.sysref = sysref_r;
   assign lk.sync_n = sync_n_r;
   assign lk.cal_trig = hctl_r[HC_CALIBRATION_TRIGGER_PIN];
   assign lk.pd_pin = hctl_r[HC_PD];
endmodule
`default_nettype wire

// ### test/lam_asserts.sv
// Checker on the signals between the two ends.
// Assumes tb instantiates it beside lam_if, same clk.
`timescale 1ns/1ps
`default_nettype none
module lam_asserts
   import lam_pkg::*;
(
   input wire logic clk, // Clock
   input wire logic rst_n, // Reset, active low
   input wire logic [AW-1:0] addr, // Device address
   input wire logic [DW-1:0] wdata, // Device write data
   input wire logic wr, // Write strobe
   input wire logic rd, // Read strobe
   input wire logic [DW-1:0] rdata, // Read data
   input wire logic sync_n, // Sync request, active low
   input wire logic cal_state, // Status pin
   input var lam_link_t phase // Link state
);
   logic [7:0] ctrl_r;
   logic pm1_w_r;
   wire ctrl_wr = wr && addr == A_CTRL;
   wire pm_wr = wr && addr inside {A_PM1, A_PM2, A_PM3, A_PM4};
   // Shadow of control, seen only through the link writes
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         ctrl_r <= CTRL_RST;
         pm1_w_r <= 1'b0;
      end else begin
         if (ctrl_wr)
            ctrl_r <= wdata;
         if (wr && addr == A_PM1)
            pm1_w_r <= 1'b1;
      end
   end
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);
   a_reset_idle: assert property ($rose(rst_n) |-> phase == LK_OFF && rdata == 8'h00)
      else $error("link not idle after reset");
   a_link_off: assert property (ctrl_wr && !wdata[C_EN] |-> ##[1:3] phase == LK_OFF)
      else $error("link stays up after disable");
   a_pm1_reset: assert property (rd && addr == A_PM1 && !pm1_w_r |=> rdata == PM1_RST)
      else $error("power mode one reset value wrong");
   a_pm_guard: assert property (pm_wr |-> !ctrl_r[C_EN] && !ctrl_r[C_CALEN])
      else $error("power mode write while link or cal on");
   a_param_hold: assert property (ctrl_wr && ctrl_r[C_EN] && wdata[C_EN] |-> wdata[2:1] == ctrl_r[2:1])
      else $error("link parameter changed while enabled");
   a_enc64_noalign: assert property (ctrl_r[C_EN] && ctrl_r[C_ENC64] |-> phase inside {LK_OFF, LK_DATA})
      else $error("alignment phase in 64b66b mode");
   a_free_data: assert property ($rose(ctrl_r[C_EN]) && ctrl_r[C_ENC64] && ctrl_r[C_SC0]
      |-> ##[1:80] phase == LK_DATA)
      else $error("no data state without sysref");
   a_sync_cgs: assert property ((ctrl_r[C_EN] && !ctrl_r[C_ENC64] && !sync_n) [*3] |-> ##[0:4] phase == LK_CGS)
      else $error("sync request ignored");
   a_pin_alarm: assert property ((ctrl_r[C_PINSEL] && phase != LK_DATA) [*3] |-> ##[0:2] cal_state)
      else $error("alarm pin low during alarm");
   c_data: cover property (phase == LK_DATA);
   c_cgs: cover property (phase == LK_CGS);
   c_pin: cover property (ctrl_r[C_PINSEL] && cal_state);
endmodule
`default_nettype wire

// ### test/tb.sv
// Testbench: both ends joined by lam_if, software port driven.
// Assumes 200 MHz clk and the bridge timing of the host end.
`timescale 1ns/1ps
`default_nettype none
module tb;
   import lam_pkg::*;
   logic clk = 0, rst_n = 0, wr = 0, rd = 0, cpll = 1, cha = 0, upset = 0, sref = 0;
   logic [2:0] a = '0;
   logic [7:0] wd = '0, rdat, v;
   logic [3:0] lanes = '0, ferr = '0;
   logic link_rst, ser_pd, clk_en, fifo_rst, swap, glitch_ok, released, edge_p;
   int n_errors = 0, tests_run = 0, cyc = 0, trig_t = 0, swap_t = 0, nswap = 0, nfrst = 0, nedge = 0;
   initial forever #2.5 clk = ~clk;
   lam_if lk (.clk(clk));
   lam_dev i_lam_dev (.clk(clk), .rst_n(rst_n), .lk(lk.dev), .cpll_lock(cpll), .spll_lock(1'b1),
      .chan_a_clk(cha), .chan_b_clk(cha ^ upset), .fifo_ptr_err(ferr), .link_rst(link_rst), .ser_pd(ser_pd),
      .link_clk_en(clk_en), .fifo_rst(fifo_rst), .lmfc_edge(edge_p), .core_swap(swap), .glitch_ok(glitch_ok),
      .pm_cfg1(), .pm_cfg2(), .pm_cfg3(), .pm_cfg4());
   lam_host i_lam_host (.clk(clk), .rst_n(rst_n), .lk(lk.host), .addr(a), .wdata(wd), .wr(wr), .rd(rd),
      .rdata(rdat), .sysref_in(sref), .lane_arrived(lanes), .buf_release(), .released(released));
   lam_asserts i_lam_asserts (.clk(clk), .rst_n(rst_n), .addr(lk.addr), .wdata(lk.wdata), .wr(lk.wr),
      .rd(lk.rd), .rdata(lk.rdata), .sync_n(lk.sync_n), .cal_state(lk.cal_state), .phase(lk.phase));
   task automatic tally_and_finish();
      $display("Checks %0d, mismatches %0d", tests_run, n_errors);
      if (n_errors == 0 && tests_run > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask
   always @(posedge clk) begin
      cha <= ~cha;
      cyc <= cyc + 1;
      if (swap) begin
         swap_t <= cyc;
         nswap <= nswap + 1;
      end
      if (fifo_rst)
         nfrst <= nfrst + 1;
      if (edge_p)
         nedge <= nedge + 1;
      if (lk.wr && lk.addr == A_SOFT_TRIG)
         trig_t <= cyc;
      if (cyc == 10000) begin
         n_errors++;
         tally_and_finish();
      end
   end
   task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
      tests_run++;
      if (seen !== exp) begin
         n_errors++;
         $display("[ERR] %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   // Gap cycle after each strobe keeps one assignment per time step
   task automatic sw(input logic [2:0] ad, input logic [7:0] d);
      a <= ad;
      wd <= d;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
      @(posedge clk);
   endtask
   task automatic srd(input logic [2:0] ad, output logic [7:0] d);
      a <= ad;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      @(posedge clk);
      d = rdat;
   endtask
   task automatic dwr(input logic [9:0] ad, input logic [7:0] d);
      sw(H_DADDR_LO, ad[7:0]);
      sw(H_DADDR_HI, {6'h00, ad[9:8]});
      sw(H_DDATA, d);
      sw(H_GO, 8'h01);
      repeat (3) @(posedge clk);
   endtask
   task automatic dchk(input string nm, input logic [9:0] ad, input logic [7:0] exp);
      logic [7:0] d;
      sw(H_DADDR_LO, ad[7:0]);
      sw(H_DADDR_HI, {6'h00, ad[9:8]});
      sw(H_GO, 8'h02);
      repeat (3) @(posedge clk);
      srd(H_DRES, d);
      chk(nm, d, exp);
   endtask
   initial begin
      repeat (2) @(posedge clk);
      rst_n <= 1'b1;
      @(posedge clk);
      chk("gating_off", {5'h00, link_rst, ser_pd, clk_en}, 8'h06);
      dchk("pm1", A_PM1, PM1_RST);
      dchk("pm2", A_PM2, PM2_RST);
      dchk("pm3", A_PM3, PM3_RST);
      chk("glitch_full", {7'h00, glitch_ok}, 8'h01);
      dwr(A_PM1, PM1_LOWPWR);
      dchk("pm1_low", A_PM1, PM1_LOWPWR);
      dwr(A_PM3, 8'h00);
      chk("glitch_low", {7'h00, glitch_ok}, 8'h00);
      $display("Test power_modes done");
      cpll <= 1'b0;
      repeat (4) @(posedge clk);
      cpll <= 1'b1;
      repeat (4) @(posedge clk);
      dchk("alm", A_ALM, 8'h05);
      dwr(A_ALM, 8'h01);
      dchk("alm_clear", A_ALM, 8'h04);
      dchk("sum", A_SUM, 8'h01);
      dwr(A_MASK, 8'h3F);
      dwr(A_ALM, 8'h3F);
      dchk("sum_masked", A_SUM, 8'h00);
      dwr(A_MASK, 8'h00);
      sref <= 1'b1;
      @(posedge clk);
      sref <= 1'b0;
      dwr(A_ALM, 8'h3F);
      repeat (20) @(posedge clk);
      // Second reference one full counter period after the first
      sref <= 1'b1;
      @(posedge clk);
      sref <= 1'b0;
      dchk("sysref_align", A_ALM, 8'h04);
      sref <= 1'b1;
      @(posedge clk);
      sref <= 1'b0;
      repeat (8) @(posedge clk);
      dchk("sysref_realign", A_ALM, 8'h0C);
      $display("Test alarms done");
      dwr(A_CTRL, 8'h45);
      chk("gating_on", {5'h00, link_rst, ser_pd, clk_en}, 8'h01);
      chk("fifo_rst", 8'(nfrst), 8'h01);
      chk("pin", {7'h00, lk.cal_state}, 8'h01);
      dwr(A_PM1, PM1_RST);
      srd(H_STAT, v);
      chk("pm_guard", v & 8'h80, 8'h80);
      sw(H_CTL, 8'h01);
      repeat (8) @(posedge clk);
      sw(H_CTL, 8'h00);
      repeat (200) @(posedge clk);
      dchk("phase", A_LSTAT, {6'h00, LK_DATA});
      lanes <= 4'h7;
      repeat (150) @(posedge clk);
      chk("held", {7'h00, released}, 8'h00);
      lanes <= 4'hF;
      repeat (150) @(posedge clk);
      chk("released", {7'h00, released}, 8'h01);
      ferr <= 4'h4;
      @(posedge clk);
      ferr <= 4'h0;
      dchk("fifo_lane", A_FIFO, 8'h04);
      dwr(A_ALM, 8'h3F);
      upset <= 1'b1;
      repeat (4) @(posedge clk);
      upset <= 1'b0;
      dchk("clk_upset", A_ALM, 8'h10);
      sw(H_GO, 8'h04);
      repeat (6) @(posedge clk);
      dchk("clk_seq", A_ALM, 8'h04);
      $display("Test link done");
      dwr(A_CTRL, 8'h00);
      dwr(A_CTRL, 8'h07);
      repeat (80) @(posedge clk);
      dchk("phase64", A_LSTAT, {6'h00, LK_DATA});
      v = 8'(nedge);
      repeat (128) @(posedge clk);
      chk("lmfc64", 8'(nedge) - v, 8'h02);
      dwr(A_CTRL, 8'h00);
      dwr(A_CTRL, 8'h2D);
      dwr(A_SOFT_TRIG, 8'h01);
      repeat (1100) @(posedge clk);
      chk("swap_n", 8'(nswap), 8'h01);
      chk("swap_dly", {7'h00, swap_t - trig_t >= 500 && swap_t - trig_t <= 1000}, 8'h01);
      dwr(A_CTRL, 8'h00);
      dwr(A_CTRL, 8'h3D);
      dwr(A_SOFT_TRIG, 8'h01);
      repeat (1100) @(posedge clk);
      chk("fg_swap_n", 8'(nswap), 8'h01);
      $display("Test core_swap done");
      tally_and_finish();
   end
endmodule
`default_nettype wire
